// ==== shared/csdec_pkg.sv ====
// Purpose: shared constants for the chip-select address decoder
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: base/mask pairs sit at a stride of 12 bytes per select
package csdec_pkg;
  localparam int NUM_SEL = 8;
  localparam logic [11:0] SEL_FIRST_OFF = 12'h080;
  localparam logic [11:0] SEL_STRIDE = 12'h00c;
  localparam logic [11:0] BASE_OFF = 12'h000;
  localparam logic [11:0] MASK_OFF = 12'h004;
  localparam logic [11:0] STATUS_OFF = 12'h0e0;
  localparam int ADDR_HI = 31;
  localparam int ADDR_LO = 16;
  localparam int IGN_LSB = 16;
  localparam int IGN_MSB = 31;
  localparam int WGUARD_BIT = 8;
  localparam int ALTM_BIT = 6;
  localparam int CPUSP_BIT = 5;
  localparam int SCODE_BIT = 4;
  localparam int SDATA_BIT = 3;
  localparam int UCODE_BIT = 2;
  localparam int UDATA_BIT = 1;
  localparam int OK_BIT = 0;
  localparam logic [31:0] MASK_WMASK = 32'hffff017f;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [31:0] MASK_RST = 32'h00000000;
  localparam int BLOCK_LOG_BASE = 16;
  typedef enum logic [2:0] {
    CSDEC_CPU_SPACE, CSDEC_SUP_CODE, CSDEC_SUP_DATA, CSDEC_USER_CODE, CSDEC_USER_DATA
  } csdec_space_e;
endpackage

// ==== hdl/csdec_match.sv ====
// Purpose: one select's address and access-type decode
// Assumes: combinational, fed from registered configuration
// Notes: hit excludes the valid flag; the top adds it
`timescale 1ns/10ps
module csdec_match (
  // configuration
  input wire logic [15:0] baseVal,
  input wire logic [31:0] maskVal,
  // access
  input wire logic [31:0] accAddr,
  input wire logic accWrite,
  input wire logic accAlt,
  input wire logic [2:0] accSpace,
  // result
  output logic hit
);
  logic [15:0] ignore;
  logic addrOk;
  logic typeMasked;
  logic wrBlocked;
  always_comb begin
    ignore = maskVal[csdec_pkg::IGN_MSB:csdec_pkg::IGN_LSB];
    addrOk = ((accAddr[csdec_pkg::ADDR_HI:csdec_pkg::ADDR_LO] ^ baseVal) & ~ignore) == 16'h0000;
    unique case (accSpace)
      csdec_pkg::CSDEC_CPU_SPACE: typeMasked = maskVal[csdec_pkg::CPUSP_BIT];
      csdec_pkg::CSDEC_SUP_CODE: typeMasked = maskVal[csdec_pkg::SCODE_BIT];
      csdec_pkg::CSDEC_SUP_DATA: typeMasked = maskVal[csdec_pkg::SDATA_BIT];
      csdec_pkg::CSDEC_USER_CODE: typeMasked = maskVal[csdec_pkg::UCODE_BIT];
      csdec_pkg::CSDEC_USER_DATA: typeMasked = maskVal[csdec_pkg::UDATA_BIT];
      default: typeMasked = 1'b1;
    endcase
    if (accAlt && !maskVal[csdec_pkg::ALTM_BIT] && accSpace != csdec_pkg::CSDEC_CPU_SPACE) begin
      typeMasked = 1'b0;
    end
    wrBlocked = accWrite && maskVal[csdec_pkg::WGUARD_BIT];
    hit = addrOk && !typeMasked && !wrBlocked;
  end
endmodule // csdec_match

// ==== hdl/csdec_apb.sv ====
// Purpose: apb slave front end for the decoder registers
// Assumes: zero wait states, pready tied high by this logic
// Notes: unmapped addresses read zero, writes ignored, pslverr low
`timescale 1ns/10ps
module csdec_apb (
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic pready,
  output logic pslverr,
  // decoded strobes
  output logic wrStb,
  output logic rdStb
);
  always_comb begin
    pready = 1'b1;
    pslverr = 1'b0;
    wrStb = psel && penable && pwrite;
    rdStb = psel && penable && !pwrite;
  end
endmodule // csdec_apb

// ==== hdl/csdec_top.sv ====
// Purpose: eight-way chip-select address decoder with apb registers
// Assumes: access signals come from logic on the same clock
// Notes: selects are registered, one cycle after the access is presented
// Summary of operation
// - each select compares its base against address bits 31 to 16.
// - each set ignore bit makes its address bit a don't-care.
// - block size is two to the power of sixteen plus the set ignore bits.
// - with write_guard set, writes do not assert the select and raise nothing.
// - alt masters with alt_master_qualify clear ignore the four code/data masks.
// - five space masks: cpu space, sup code, sup data, user code, user data.
// - a masked access type leaves the select off while a normal cycle runs.
// - outside global mode, a select never asserts while its entry_ok_flag is clear.
// - reset clears every entry_ok_flag.
// - after reset the boot select asserts for every access, others stay off.
// - once boot valid is set, global mode returns only with system reset.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module csdec_top #(
  parameter int NUM_SEL = csdec_pkg::NUM_SEL
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // access under decode
  input wire logic accValid,
  input wire logic [31:0] accAddr,
  input wire logic accWrite,
  input wire logic accAlt,
  input wire logic [2:0] accSpace,
  // selects, active low
  output logic [NUM_SEL-1:0] selOut_n,
  output logic bootGlobal
);
  initial begin
    if (NUM_SEL < 1 || NUM_SEL > 8) begin
      $error("NUM_SEL must be 1 to 8");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic wrStb;
  logic rdStb;
  logic [15:0] base_q [NUM_SEL];
  logic [15:0] base_d [NUM_SEL];
  logic [31:0] mask_q [NUM_SEL];
  logic [31:0] mask_d [NUM_SEL];
  logic globalMode_q;
  logic globalMode_d;
  logic [NUM_SEL-1:0] sel_q;
  logic [NUM_SEL-1:0] sel_d;
  logic [NUM_SEL-1:0] hit;
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  // register index for an offset, or -1
  function automatic int regSlot(input logic [11:0] a, input logic isMask);
    int s;
    logic [11:0] off;
    regSlot = -1;
    for (s = 0; s < NUM_SEL; s++) begin
      off = csdec_pkg::SEL_FIRST_OFF + 12'(s) * csdec_pkg::SEL_STRIDE
          + (isMask ? csdec_pkg::MASK_OFF : csdec_pkg::BASE_OFF);
      if (a == off) begin
        regSlot = s;
      end
    end
  endfunction

  csdec_apb uApb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .wrStb(wrStb),
    .rdStb(rdStb)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register writes
  always_comb begin
    int bs;
    int ms;
    bs = regSlot(paddr, 1'b0);
    ms = regSlot(paddr, 1'b1);
    for (int i = 0; i < NUM_SEL; i++) begin
      base_d[i] = base_q[i];
      mask_d[i] = mask_q[i];
      if (wrStb && bs == i) begin
        base_d[i] = pwdata[15:0];
      end
      if (wrStb && ms == i) begin
        mask_d[i] = pwdata & csdec_pkg::MASK_WMASK;
      end
    end
    globalMode_d = globalMode_q && !mask_q[0][csdec_pkg::OK_BIT];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        base_q[i] <= csdec_pkg::BASE_RST;
        mask_q[i] <= csdec_pkg::MASK_RST;
      end
      globalMode_q <= 1'b1;
    end else begin
      for (int i = 0; i < NUM_SEL; i++) begin
        base_q[i] <= base_d[i];
        mask_q[i] <= mask_d[i];
      end
      globalMode_q <= globalMode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data
  always_comb begin
    int bs;
    int ms;
    bs = regSlot(paddr, 1'b0);
    ms = regSlot(paddr, 1'b1);
    rd_d = 32'h00000000;
    if (bs >= 0) begin
      rd_d = {base_q[bs], 16'h0000};
    end else if (ms >= 0) begin
      rd_d = mask_q[ms];
    end else if (paddr == csdec_pkg::STATUS_OFF) begin
      rd_d = {23'h0, globalMode_q, 8'(sel_q)};
    end
    if (!(psel && !penable && !pwrite)) begin
      rd_d = rd_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 32'h00000000;
    end else begin
      rd_q <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  genvar g;
  generate
    for (g = 0; g < NUM_SEL; g++) begin : gSel
      csdec_match uMatch (
        .baseVal(base_q[g]),
        .maskVal(mask_q[g]),
        .accAddr(accAddr),
        .accWrite(accWrite),
        .accAlt(accAlt),
        .accSpace(accSpace),
        .hit(hit[g])
      );
    end
  endgenerate

  always_comb begin
    sel_d = '0;
    for (int i = 0; i < NUM_SEL; i++) begin
      if (accValid && !globalMode_q && mask_q[i][csdec_pkg::OK_BIT] && hit[i]) begin
        sel_d[i] = 1'b1;
      end
    end
    if (accValid && globalMode_q) begin
      sel_d[0] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= '0;
    end else begin
      sel_q <= sel_d;
    end
  end

  always_comb begin
    selOut_n = ~sel_q;
    prdata = rd_q;
    bootGlobal = globalMode_q;
  end
endmodule // csdec_top

// ==== tb/csdec_props.sv ====
// Purpose: port checks for the select decoder
// Assumes: one clock, async active-low reset
// Notes: bound to csdec_top
`timescale 1ns/10ps
module csdec_props #(
  parameter int NUM_SEL = 8
) (
  // clock, reset, apb
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // decode
  input wire logic accValid,
  input wire logic [NUM_SEL-1:0] selOut_n,
  input wire logic bootGlobal
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic bootWr;
  assign bootWr = psel && penable && pwrite && paddr == 12'h084 && pwdata[0];
  ////////////////////////////////
  reset_state_a: assert property ($rose(rst_n) |-> bootGlobal && &selOut_n)
    else $error("bad state after reset");
  boot_only_a: assert property (bootGlobal && accValid && !bootWr |=> !selOut_n[0])
    else $error("boot select missing");
  boot_others_a: assert property (bootGlobal |=> &selOut_n[NUM_SEL-1:1])
    else $error("select during boot");
  boot_sticky_a: assert property (!bootGlobal |=> !bootGlobal)
    else $error("global mode came back");
  boot_exit_a: assert property (bootWr |-> ##2 !bootGlobal)
    else $error("boot valid ignored");
  boot_cause_a: assert property ($fell(bootGlobal) |-> $past(bootWr, 2))
    else $error("global left without write");
  idle_off_a: assert property (!accValid |=> &selOut_n)
    else $error("select without access");
  status_boot_a: assert property (psel && penable && !pwrite && paddr == 12'h0e0
    |-> prdata[8] == $past(bootGlobal))
    else $error("status flag wrong");
  boot_c: cover property (bootGlobal && accValid);
  exit_c: cover property ($fell(bootGlobal));
  sel1_c: cover property (!selOut_n[1]);
endmodule // csdec_props
bind csdec_top csdec_props #(.NUM_SEL(NUM_SEL)) csdec_props_inst (.clock(clock),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .accValid(accValid), .selOut_n(selOut_n),
  .bootGlobal(bootGlobal));

// ==== tb/csdec_mem_model.sv ====
// Purpose: external device side, records which selects fired
// Assumes: selects active low
// Notes: a deselected device just waits
`timescale 1ns/10ps
module csdec_mem_model #(
  parameter int NUM_SEL = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // selects in, seen flags out
  input wire logic [NUM_SEL-1:0] selOut_n,
  output logic [NUM_SEL-1:0] seenSel_q
);
  logic [NUM_SEL-1:0] seenSel_d;
  always_comb begin
    seenSel_d = seenSel_q | ~selOut_n;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seenSel_q <= '0;
    end else begin
      seenSel_q <= seenSel_d;
    end
  end
endmodule // csdec_mem_model

// ==== tb/tb_top.sv ====
// Purpose: directed bench for the select decoder
// Assumes: apb slave answers by pready, selects one edge after access
// Notes: expected selects are active low
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module tb_top;
  localparam logic [31:0] AD = 32'h0210_0000;
  logic clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic accValid = 1'h0, accWrite = 1'h0, accAlt = 1'h0;
  logic [2:0] accSpace = 3'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, accAddr = 32'h0, rdVal, prdata;
  logic pready, pslverr, bootGlobal;
  logic [7:0] selOut_n, seenSel;
  int n_mismatch = 0, comparisons = 0;
  csdec_top csdec_top_inst (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .accValid(accValid), .accAddr(accAddr), .accWrite(accWrite),
    .accAlt(accAlt), .accSpace(accSpace), .selOut_n(selOut_n), .bootGlobal(bootGlobal));
  csdec_mem_model csdec_mem_model_inst (.clock(clock), .rst_n(rst_n),
    .selOut_n(selOut_n), .seenSel_q(seenSel));
  initial begin
    forever #10 clock = ~clock;
  end
  ////////////////////////////////
  task automatic end_sim();
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [11:0] rg(input int n, input int m);
    return 12'h080 + 12'(n * 12 + m * 4);
  endfunction
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (pready !== 1'h1) begin
      n_mismatch++;
      end_sim();
    end
    rdVal = prdata;
    `CHK(pslverr, 1'h0)
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic acc(input logic [31:0] a, input logic w, input logic alt,
      input logic [2:0] s, input logic [7:0] e);
    @(posedge clock);
    accValid <= 1'h1;
    accAddr <= a;
    accWrite <= w;
    accAlt <= alt;
    accSpace <= s;
    @(posedge clock);
    accValid <= 1'h0;
    @(negedge clock);
    `CHK(selOut_n, e)
  endtask
  ////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    for (int n = 0; n < 8; n++) begin
      apb(rg(n, 1), 1'h0, 32'h0);
      `CHK(rdVal, 32'h0)
    end
    $display("reset test done");
    apb(rg(1, 0), 1'h1, 32'h0200);
    apb(rg(1, 1), 1'h1, 32'h00ff_0001);
    acc(AD, 1'h1, 1'h0, 3'h4, 8'hfe);
    acc(32'h7000_0000, 1'h0, 1'h1, 3'h0, 8'hfe);
    $display("boot test done");
    apb(rg(0, 0), 1'h1, 32'h0);
    apb(rg(0, 1), 1'h1, 32'h0008_0001);
    acc(32'h0000_1000, 1'h0, 1'h0, 3'h4, 8'hfe);
    acc(32'h0008_ff00, 1'h0, 1'h0, 3'h4, 8'hfe);
    acc(32'h0004_0000, 1'h0, 1'h0, 3'h4, 8'hff);
    acc(32'h02ff_fff0, 1'h0, 1'h0, 3'h4, 8'hfd);
    acc(32'h0300_0000, 1'h0, 1'h0, 3'h4, 8'hff);
    apb(rg(1, 0), 1'h0, 32'h0);
    `CHK(rdVal, 32'h0200_0000)
    $display("decode test done");
    apb(rg(1, 1), 1'h1, 32'h00ff_0101);
    acc(AD, 1'h1, 1'h0, 3'h4, 8'hff);
    acc(AD, 1'h0, 1'h0, 3'h4, 8'hfd);
    for (int s = 0; s < 5; s++) begin
      apb(rg(1, 1), 1'h1, 32'h00ff_0001 | (32'h1 << (5 - s)));
      acc(AD, 1'h0, 1'h0, 3'(s), 8'hff);
      acc(AD, 1'h0, 1'h1, 3'(s), (s == 0) ? 8'hff : 8'hfd);
      apb(rg(1, 1), 1'h1, 32'h00ff_0041 | (32'h1 << (5 - s)));
      acc(AD, 1'h0, 1'h1, 3'(s), 8'hff);
    end
    $display("type test done");
    apb(rg(2, 1), 1'h1, 32'hffff_ffff);
    apb(rg(2, 1), 1'h0, 32'h0);
    `CHK(rdVal, 32'hffff_017f)
    apb(12'h0e4, 1'h0, 32'h0);
    `CHK(rdVal, 32'h0)
    apb(rg(1, 1), 1'h1, 32'h00ff_0000);
    acc(AD, 1'h0, 1'h0, 3'h4, 8'hff);
    apb(rg(0, 1), 1'h1, 32'h0008_0000);
    apb(12'h0e0, 1'h0, 32'h0);
    `CHK(rdVal[8], 1'h0)
    acc(32'h0000_0000, 1'h0, 1'h0, 3'h4, 8'hff);
    `CHK(seenSel, 8'h03)
    $display("valid test done");
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    apb(rg(2, 1), 1'h0, 32'h0);
    `CHK(rdVal, 32'h0)
    acc(AD, 1'h0, 1'h0, 3'h4, 8'hfe);
    $display("second reset test done");
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end
endmodule // tb_top
